// *** core/irq_status_params.svh ***
`ifndef IRQ_STATUS_PARAMS_SVH
`define IRQ_STATUS_PARAMS_SVH

// Register port geometry
`define REG_ADDR_W 12
`define REG_DATA_W 32

// Register byte offsets
`define CHIP_ID_OFF 12'h000
`define IRQ_STS_OFF 12'h00c
`define MAC_CTRL_OFF 12'h100

// Identity word fields
`define ID_MODEL_HI 31
`define ID_MODEL_LO 16
`define CHIP_IDENTITY_WORD_HI 15
`define CHIP_IDENTITY_WORD_LO 0

// Status word field positions
`define STS_RSVD_HI 31
`define STS_RSVD_LO 29
`define STS_OTP_BIT 28
`define STS_RSVD_MID_BIT 27
`define STS_TX_ENTRY_BIT 26
`define STS_TX_EXIT_BIT 25
`define STS_RX_ENTRY_BIT 24
`define STS_RST_TMO_BIT 23
`define STS_RX_OVF_BIT 22
`define STS_TX_ERR_BIT 21
`define STS_USB_BIT 20
`define STS_TX_DIS_BIT 19
`define STS_RX_DIS_BIT 18
`define STS_PHY_BIT 17

// Fixed value of the top reserved field
`define STS_RSVD_VAL 3'h0

// Energy saving enable position in the MAC control word
`define MAC_EEE_EN_BIT 0
`define MAC_EEE_EN_RST 1'b0

// Reset watchdog timing
`define CLK_HZ 100000000
`define MS_PER_SEC 1000
`define RST_WDOG_MS 8

`endif

// *** core/irq_status_pkg.sv ***
`include "irq_status_params.svh"

package irq_status_pkg;

  // Event and level sources from the neighbouring units
  typedef struct packed {
    logic otp_wr_done;
    logic tx_idle_entry;
    logic tx_idle_exit;
    logic rx_idle_entry;
    logic mac_rst_held;
    logic phy_clocks_ok;
    logic rx_wr_req;
    logic rx_fifo_full;
    logic tx_error;
    logic usb_event;
    logic tx_fifo_disabled;
    logic tx_mac_disabled;
    logic rx_fifo_disabled;
    logic rx_mac_disabled;
    logic external_transceiver_irq_pin_n;
  } sources_s;

  // One register port request
  typedef struct packed {
    logic [`REG_ADDR_W-1:0] addr;
    logic [`REG_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // Reset watchdog states
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_COUNT = 2'b01,
    WD_DONE = 2'b10
  } wdog_e;

endpackage

// *** core/irq_status_id.sv ***
// What this block does
// - Bit 28 flags finished one-time memory write
// - Write-done flag follows level until source clears
// - Bit 26 latches transmitter idle entry pulse
// - Bit 25 latches transmitter idle exit pulse
// - Pulse flag latches receiver idle entry
// - Idle flags forced zero while saving disabled
// - Watchdog times 8 ms, sets sticky timeout flag
// - Watchdog expiry releases MAC reset
// - Overflow level on full write, data dropped
// - USB flag follows level until events cleared
// - Identity bits 31:16 fixed model, unwritable
// - Identity bits 15:0 give silicon revision
// - Transmit disabled flag while either indication set
// - Transceiver flag follows active-low interrupt pin
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "irq_status_params.svh"

module irq_status_id
  import irq_status_pkg::*;
#(
  // Model code value is arbitrary
  parameter logic [15:0] CHIP_MODEL = 16'h5a5a,
  // Revision value is arbitrary
  parameter logic [15:0] CHIP_REV = 16'h0001,
  parameter int unsigned WDOG_CYCLES = (`CLK_HZ / `MS_PER_SEC) * `RST_WDOG_MS
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire bus_req_s bus,
  input wire sources_s src,
  output logic [`REG_DATA_W-1:0] rd_data_q,
  output logic mac_reset_release_q,
  output logic rx_wr_accept_q,
  output logic energy_saving_enable_q
);

  localparam int CW = $clog2(WDOG_CYCLES + 1);
  localparam logic [CW-1:0] WDOG_LAST = CW'(WDOG_CYCLES - 1);

  // Address decode shared by the register and flag logic
  logic hit_id;
  logic hit_sts;
  logic hit_mac;
  logic [`REG_DATA_W-1:0] sts_word;
  logic [`REG_DATA_W-1:0] rd_data_d;

  assign hit_id = bus.addr == `CHIP_ID_OFF;
  assign hit_sts = bus.addr == `IRQ_STS_OFF;
  assign hit_mac = bus.addr == `MAC_CTRL_OFF;

  // Software control: energy saving enable
  logic energy_saving_enable_d;

  always_comb
  begin
    energy_saving_enable_d = energy_saving_enable_q;
    if (bus.wr && hit_mac)
    begin
      energy_saving_enable_d = bus.wdata[`MAC_EEE_EN_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      energy_saving_enable_q <= `MAC_EEE_EN_RST;
    else if (ce)
      energy_saving_enable_q <= energy_saving_enable_d;
  end

  // Reset watchdog; counts only while reset waits on absent PHY clocks
  wdog_e wd_state_q;
  wdog_e wd_state_d;
  logic [CW-1:0] wd_cnt_q;
  logic [CW-1:0] wd_cnt_d;
  logic wd_expire;
  logic mac_reset_release_d;

  always_comb
  begin
    wd_state_d = wd_state_q;
    wd_cnt_d = wd_cnt_q;
    wd_expire = 1'b0;
    case (wd_state_q)
      WD_IDLE:
      begin
        wd_cnt_d = '0;
        if (src.mac_rst_held && !src.phy_clocks_ok)
          wd_state_d = WD_COUNT;
      end
      WD_COUNT:
      begin
        if (!src.mac_rst_held || src.phy_clocks_ok)
        begin
          wd_state_d = WD_IDLE;
          wd_cnt_d = '0;
        end
        else if (wd_cnt_q == WDOG_LAST)
        begin
          wd_state_d = WD_DONE;
          wd_expire = 1'b1;
        end
        else
          wd_cnt_d = wd_cnt_q + 1'b1;
      end
      WD_DONE:
      begin
        // Stay released until the reset request itself goes away
        if (!src.mac_rst_held)
          wd_state_d = WD_IDLE;
      end
      default:
        wd_state_d = WD_IDLE;
    endcase
    mac_reset_release_d = (wd_state_d == WD_DONE);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wd_state_q <= WD_IDLE;
      wd_cnt_q <= '0;
      mac_reset_release_q <= 1'b0;
    end
    else if (ce)
    begin
      wd_state_q <= wd_state_d;
      wd_cnt_q <= wd_cnt_d;
      mac_reset_release_q <= mac_reset_release_d;
    end
  end

  // Sticky pulse flags; a set in the clearing cycle wins
  logic tx_idle_entry_flag_q;
  logic tx_idle_entry_flag_d;
  logic tx_idle_exit_flag_q;
  logic tx_idle_exit_flag_d;
  logic rx_idle_entry_flag_q;
  logic rx_idle_entry_flag_d;
  logic mac_reset_timeout_flag_q;
  logic mac_reset_timeout_flag_d;
  logic [`REG_DATA_W-1:0] clr;

  assign clr = (bus.wr && hit_sts) ? bus.wdata : '0;

  always_comb
  begin
    tx_idle_entry_flag_d = src.tx_idle_entry |
      (tx_idle_entry_flag_q & ~clr[`STS_TX_ENTRY_BIT]);
    tx_idle_exit_flag_d = src.tx_idle_exit |
      (tx_idle_exit_flag_q & ~clr[`STS_TX_EXIT_BIT]);
    rx_idle_entry_flag_d = src.rx_idle_entry |
      (rx_idle_entry_flag_q & ~clr[`STS_RX_ENTRY_BIT]);
    mac_reset_timeout_flag_d = wd_expire |
      (mac_reset_timeout_flag_q & ~clr[`STS_RST_TMO_BIT]);
    if (!energy_saving_enable_q)
    begin
      tx_idle_entry_flag_d = 1'b0;
      tx_idle_exit_flag_d = 1'b0;
      rx_idle_entry_flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_idle_entry_flag_q <= 1'b0;
      tx_idle_exit_flag_q <= 1'b0;
      rx_idle_entry_flag_q <= 1'b0;
      mac_reset_timeout_flag_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_idle_entry_flag_q <= tx_idle_entry_flag_d;
      tx_idle_exit_flag_q <= tx_idle_exit_flag_d;
      rx_idle_entry_flag_q <= rx_idle_entry_flag_d;
      mac_reset_timeout_flag_q <= mac_reset_timeout_flag_d;
    end
  end

  // Level flags; software writes cannot clear them, only the source can
  logic otp_done_flag_q;
  logic rx_fifo_overflow_flag_q;
  logic rx_fifo_overflow_flag_d;
  logic rx_wr_accept_d;
  logic transmit_error_flag_q;
  logic usb_event_flag_q;
  logic transmit_disabled_flag_q;
  logic transmit_disabled_flag_d;
  logic rx_disabled_flag_q;
  logic rx_disabled_flag_d;
  logic external_transceiver_flag_q;
  logic external_transceiver_flag_d;

  always_comb
  begin
    rx_fifo_overflow_flag_d = src.rx_fifo_full &
      (rx_fifo_overflow_flag_q | src.rx_wr_req);
    rx_wr_accept_d = src.rx_wr_req & ~src.rx_fifo_full;
    transmit_disabled_flag_d = src.tx_fifo_disabled | src.tx_mac_disabled;
    rx_disabled_flag_d = src.rx_fifo_disabled | src.rx_mac_disabled;
    external_transceiver_flag_d = ~src.external_transceiver_irq_pin_n;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      otp_done_flag_q <= 1'b0;
      rx_fifo_overflow_flag_q <= 1'b0;
      rx_wr_accept_q <= 1'b0;
      transmit_error_flag_q <= 1'b0;
      usb_event_flag_q <= 1'b0;
      transmit_disabled_flag_q <= 1'b0;
      rx_disabled_flag_q <= 1'b0;
      external_transceiver_flag_q <= 1'b0;
    end
    else if (ce)
    begin
      otp_done_flag_q <= src.otp_wr_done;
      rx_fifo_overflow_flag_q <= rx_fifo_overflow_flag_d;
      rx_wr_accept_q <= rx_wr_accept_d;
      transmit_error_flag_q <= src.tx_error;
      usb_event_flag_q <= src.usb_event;
      transmit_disabled_flag_q <= transmit_disabled_flag_d;
      rx_disabled_flag_q <= rx_disabled_flag_d;
      external_transceiver_flag_q <= external_transceiver_flag_d;
    end
  end

  // Read mux; data stand one cycle after the strobe and are zero otherwise
  always_comb
  begin
    sts_word = '0;
    sts_word[`STS_RSVD_HI:`STS_RSVD_LO] = `STS_RSVD_VAL;
    sts_word[`STS_RSVD_MID_BIT] = 1'b0;
    sts_word[`STS_OTP_BIT] = otp_done_flag_q;
    sts_word[`STS_TX_ENTRY_BIT] = tx_idle_entry_flag_q;
    sts_word[`STS_TX_EXIT_BIT] = tx_idle_exit_flag_q;
    sts_word[`STS_RX_ENTRY_BIT] = rx_idle_entry_flag_q;
    sts_word[`STS_RST_TMO_BIT] = mac_reset_timeout_flag_q;
    sts_word[`STS_RX_OVF_BIT] = rx_fifo_overflow_flag_q;
    sts_word[`STS_TX_ERR_BIT] = transmit_error_flag_q;
    sts_word[`STS_USB_BIT] = usb_event_flag_q;
    sts_word[`STS_TX_DIS_BIT] = transmit_disabled_flag_q;
    sts_word[`STS_RX_DIS_BIT] = rx_disabled_flag_q;
    sts_word[`STS_PHY_BIT] = external_transceiver_flag_q;
    rd_data_d = '0;
    if (bus.rd)
    begin
      if (hit_id)
      begin
        rd_data_d[`ID_MODEL_HI:`ID_MODEL_LO] = CHIP_MODEL;
        rd_data_d[`CHIP_IDENTITY_WORD_HI:`CHIP_IDENTITY_WORD_LO] = CHIP_REV;
      end
      else if (hit_sts)
        rd_data_d = sts_word;
      else if (hit_mac)
        rd_data_d[`MAC_EEE_EN_BIT] = energy_saving_enable_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data_q <= '0;
    else if (ce)
      rd_data_q <= rd_data_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wd_last;
    ce && wd_state_q == WD_COUNT && wd_cnt_q == WDOG_LAST &&
      src.mac_rst_held && !src.phy_clocks_ok;
  endsequence

  sequence s_wd_fired;
    mac_reset_timeout_flag_q && mac_reset_release_q;
  endsequence

  a_wdog_expiry: assert property (s_wd_last |=> s_wd_fired)
    else $error("watchdog expiry did not flag and release");
  a_release_timed: assert property (
    $rose(mac_reset_release_q) |-> $past(wd_cnt_q) == WDOG_LAST)
    else $error("reset released before full watchdog count");
  a_tx_entry_set: assert property (
    ce && src.tx_idle_entry && energy_saving_enable_q |=>
      tx_idle_entry_flag_q)
    else $error("transmit idle entry not latched");
  a_tx_exit_set: assert property (
    ce && src.tx_idle_exit && energy_saving_enable_q |=>
      tx_idle_exit_flag_q)
    else $error("transmit idle exit not latched");
  a_rx_entry_set: assert property (
    ce && src.rx_idle_entry && energy_saving_enable_q |=>
      rx_idle_entry_flag_q)
    else $error("receive idle entry not latched");
  a_idle_forced_low: assert property (
    ce && !energy_saving_enable_q |=> !tx_idle_entry_flag_q &&
      !tx_idle_exit_flag_q && !rx_idle_entry_flag_q)
    else $error("idle flag set while saving disabled");
  a_ovf_discard: assert property (
    ce && src.rx_wr_req && src.rx_fifo_full |=>
      rx_fifo_overflow_flag_q && !rx_wr_accept_q)
    else $error("full write not flagged or not dropped");
  a_level_follow: assert property (
    ce |=> usb_event_flag_q == $past(src.usb_event) &&
      otp_done_flag_q == $past(src.otp_wr_done))
    else $error("level flag does not follow source");
  a_id_readback: assert property (
    ce && bus.rd && hit_id |=> rd_data_q == {CHIP_MODEL, CHIP_REV})
    else $error("identity word wrong");
  a_txdis_follow: assert property (
    ce && (src.tx_fifo_disabled || src.tx_mac_disabled) |=>
      transmit_disabled_flag_q)
    else $error("transmit disabled flag missing");
  a_pin_follow: assert property (
    ce |=> external_transceiver_flag_q ==
      !$past(src.external_transceiver_irq_pin_n))
    else $error("transceiver flag does not follow pin");
  a_sticky_clear: assert property (
    ce && mac_reset_timeout_flag_q && !wd_expire &&
      !(bus.wr && hit_sts && bus.wdata[`STS_RST_TMO_BIT]) |=>
      mac_reset_timeout_flag_q)
    else $error("sticky flag lost without a one written");
  a_rsvd_fixed: assert property (
    ce && bus.rd && hit_sts |=> rd_data_q[`STS_RSVD_MID_BIT] == 1'b0 &&
      rd_data_q[`STS_RSVD_HI:`STS_RSVD_LO] == `STS_RSVD_VAL)
    else $error("reserved status bits not fixed");

endmodule // irq_status_id

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "irq_status_params.svh"

module tb_top;
  import irq_status_pkg::*;
  // Model and revision values are arbitrary
  localparam logic [15:0] MODEL = 16'h3c96;
  localparam logic [15:0] REV = 16'h0042;
  localparam int WDOG = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  bus_req_s bus = '0;
  sources_s src = 15'h0001;
  logic [31:0] rd_data_q;
  logic mac_reset_release_q;
  logic rx_wr_accept_q;
  logic energy_saving_enable_q;
  logic [31:0] exp_q[$];
  logic rd_prev = 1'b0;
  logic [31:0] sts;
  logic [31:0] r;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'hfe3b;

  irq_status_id #(.CHIP_MODEL(MODEL), .CHIP_REV(REV), .WDOG_CYCLES(WDOG))
    irq_status_id_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .bus(bus),
    .src(src), .rd_data_q(rd_data_q),
    .mac_reset_release_q(mac_reset_release_q),
    .rx_wr_accept_q(rx_wr_accept_q),
    .energy_saving_enable_q(energy_saving_enable_q));

  // Free running 100 MHz clock
  always #5 clk = ~clk;

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read request; the expected word is noted for the monitor
  task automatic rd(logic [11:0] a, logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask

  // One-cycle event pulse on a source bit
  task automatic pulse(int i);
    @(posedge clk);
    src[i] <= 1'b1;
    @(posedge clk);
    src[i] <= 1'b0;
  endtask

  // Hang guard: generous against a run of under two hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
    rd_prev <= bus.rd & ce & ~sys_rst;

  // Monitor takes the oldest note for each read answer
  always @(negedge clk)
    if (rd_prev)
    begin
      if (exp_q.size() == 0)
        check("read queue", 32'h1, 32'h0);
      else
        check("read data", rd_data_q, exp_q.pop_front());
    end

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // Identity word is fixed and ignores writes
    rd(`CHIP_ID_OFF, {MODEL, REV});
    wr(`CHIP_ID_OFF, 32'hffffffff);
    rd(`CHIP_ID_OFF, {MODEL, REV});
    wr(`IRQ_STS_OFF, 32'hffffffff);
    rd(`IRQ_STS_OFF, 32'h0);
    // Idle events are dropped while energy saving is off
    for (int i = 0; i < 3; i++)
      pulse(13 - i);
    rd(`IRQ_STS_OFF, 32'h0);
    // A write with the clock enable low is dropped
    @(posedge clk);
    ce <= 1'b0;
    wr(`MAC_CTRL_OFF, 32'h1);
    ce <= 1'b1;
    rd(`MAC_CTRL_OFF, 32'h0);
    wr(`MAC_CTRL_OFF, 32'h1);
    rd(`MAC_CTRL_OFF, 32'h1);
    // Look away from the edge so the flop has settled
    @(negedge clk);
    check("enable", energy_saving_enable_q, 32'h1);
    sts = 32'h0;
    for (int i = 0; i < 3; i++)
    begin
      pulse(13 - i);
      sts[26 - i] = 1'b1;
      rd(`IRQ_STS_OFF, sts);
    end
    wr(`IRQ_STS_OFF, 32'h0);
    rd(`IRQ_STS_OFF, sts);
    wr(`IRQ_STS_OFF, 32'h1 << 26);
    sts[26] = 1'b0;
    rd(`IRQ_STS_OFF, sts);
    wr(`MAC_CTRL_OFF, 32'h0);
    tick(2);
    rd(`IRQ_STS_OFF, 32'h0);
    // Random level sources; writing ones must not clear them
    for (int k = 0; k < 8; k++)
    begin
      r = $random(seed);
      @(posedge clk);
      src <= {r[7], 7'h0, r[6:0]};
      tick(2);
      sts = 32'h0;
      sts[28] = r[7];
      sts[21] = r[6];
      sts[20] = r[5];
      sts[19] = r[4] | r[3];
      sts[18] = r[2] | r[1];
      sts[17] = ~r[0];
      wr(`IRQ_STS_OFF, 32'hffffffff);
      rd(`IRQ_STS_OFF, sts);
    end
    // Write acceptance follows request and fullness one cycle later
    for (int k = 0; k < 8; k++)
    begin
      r = $random(seed);
      @(posedge clk);
      // Whole word at once: request bit 8, full bit 7, pin idle high
      src <= {6'h0, r[0], r[1], 7'h01};
      @(posedge clk);
      @(negedge clk);
      check("accept", rx_wr_accept_q, {31'h0, r[0] & ~r[1]});
    end
    @(posedge clk);
    src <= 15'h0181;
    @(posedge clk);
    src.rx_wr_req <= 1'b0;
    // The write seen against a full store must be dropped
    @(negedge clk);
    check("accept full", rx_wr_accept_q, 32'h0);
    rd(`IRQ_STS_OFF, 32'h1 << 22);
    @(posedge clk);
    src.rx_fifo_full <= 1'b0;
    tick(2);
    rd(`IRQ_STS_OFF, 32'h0);
    // Clocks present while held: no timeout
    @(posedge clk);
    src <= 15'h0601;
    tick(10);
    @(negedge clk);
    check("release abort", mac_reset_release_q, 32'h0);
    // Counting starts the cycle after the clocks vanish
    @(posedge clk);
    src.phy_clocks_ok <= 1'b0;
    tick(WDOG);
    @(negedge clk);
    check("release early", mac_reset_release_q, 32'h0);
    tick(1);
    @(negedge clk);
    check("release", mac_reset_release_q, 32'h1);
    rd(`IRQ_STS_OFF, 32'h1 << 23);
    wr(`IRQ_STS_OFF, 32'h1 << 23);
    rd(`IRQ_STS_OFF, 32'h0);
    @(posedge clk);
    src.mac_rst_held <= 1'b0;
    tick(2);
    @(negedge clk);
    check("release drop", mac_reset_release_q, 32'h0);
    // Unmapped places read zero and swallow writes
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      wr({r[11:4], 4'h4}, r);
      rd({r[11:4], 4'h4}, 32'h0);
    end
    tick(3);
    end_of_test();
  end
endmodule // tb_top
